// ### pcld_pkg.sv
// pcld_pkg: constants and types shared by both ends of the pulse-count link
// assumes a single 250 MHz clock on both ends
package pcld_pkg;
    // clock rate
    localparam int CLK_MHZ         = 250;
    // times in their own units
    localparam int T_OFF_NS        = 1500000;  // low time that means shutdown
    localparam int T_PUMP_US       = 400;      // 1x to 1.5x delay
    localparam int T_SETUP_NS      = 10000;    // high time before first pulse
    localparam int T_PULSE_NS      = 1000;     // host pulse low/high time
    // derived cycle counts
    localparam int OFF_CYC   = (T_OFF_NS * CLK_MHZ + 999) / 1000;
    localparam int PUMP_CYC  = T_PUMP_US * CLK_MHZ;
    localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    // widths
    localparam int CNT_W           = 20;
    localparam int LVL_W           = 5;
    localparam int CUR_W           = 11;       // current in units of 0.1 mA
    localparam logic [LVL_W-1:0] LVL_ZERO = 5'h1F;  // level 31 is 0 mA
    localparam logic [LVL_W-1:0] LVL_FULL = 5'h00;  // level 0 is 150 mA

    // charge pump mode
    typedef enum logic [1:0]
    {
        PCLD_PUMP_OFF  = 2'b00,
        PCLD_PUMP_ONE  = 2'b01,
        PCLD_PUMP_HALF = 2'b10
    } pcld_pump_e;

    // current per level in 0.1 mA, level k is pulse count k+1
    function automatic logic [CUR_W-1:0] pcld_current(
        input logic [LVL_W-1:0] lvl);
        logic [CUR_W-1:0] tab [32];
        tab = '{11'h5DC, 11'h5AA, 11'h578, 11'h54B, 11'h51E, 11'h4EC,
                11'h4BA, 11'h488, 11'h456, 11'h429, 11'h3F7, 11'h3CA,
                11'h398, 11'h366, 11'h334, 11'h307, 11'h2D5, 11'h2A8,
                11'h276, 11'h244, 11'h212, 11'h1E5, 11'h1B3, 11'h186,
                11'h154, 11'h122, 11'h0F0, 11'h0BE, 11'h091, 11'h064,
                11'h032, 11'h000};
        return tab[lvl];
    endfunction : pcld_current
endpackage : pcld_pkg

// ### pcld_link_if.sv
// pcld_link_if: the one enable/dim wire between host and device
// assumes both ends share ref_clk_i
`timescale 1ns/100ps
interface pcld_link_if;
    logic enable_dim_input;  // driven by the host, active high

    modport host   (output enable_dim_input);
    modport device (input  enable_dim_input);
endinterface : pcld_link_if

// ### pcld_device.sv
// pcld_device: pulse-counting dimmer and charge pump mode sequencer
// assumes the link wire is asynchronous; analog stages sit outside
`timescale 1ns/100ps
module pcld_device
    import pcld_pkg::*;
(
    // clock, reset, enable
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    input  wire logic             clk_en_i,
    // link
    pcld_link_if.device           link,
    // analog status
    input  wire logic             undervoltage_lockout_i,
    input  wire logic             pump_low_i,   // 1x cannot regulate
    // outputs
    output logic                  enabled_o,
    output logic [CUR_W-1:0]      led_sink_one_o,
    output logic [CUR_W-1:0]      led_sink_two_o,
    output logic                  led_sink_one_oe_n_o,
    output logic                  led_sink_two_oe_n_o,
    output pcld_pump_e            pump_mode_o
);
    typedef struct packed {
        logic [2:0]       sync;
        logic             in_lvl;
        logic             on;
        logic             lit;
        logic [LVL_W-1:0] lvl;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] pump_cnt;
        pcld_pump_e       pump;
        logic [CUR_W-1:0] cur;
        logic             hiz;
    } pcld_dev_s;

    pcld_dev_s st_q;
    pcld_dev_s st_d;
    logic      fall;

    // next-state logic
    always_comb
    begin
        st_d = st_q;
        fall = 1'b0;
        st_d.sync = {st_q.sync[1:0], link.enable_dim_input};
        if (st_q.sync[2] == st_q.sync[1])
        begin
            fall = st_q.in_lvl & ~st_q.sync[2];
            st_d.in_lvl = st_q.sync[2];
        end
        // low period measurement
        if (st_q.in_lvl)
            st_d.low_cnt = '0;
        else if (st_q.low_cnt != CNT_W'(OFF_CYC))
            st_d.low_cnt = st_q.low_cnt + 1'b1;
        if (!st_q.on && st_q.in_lvl)
        begin
            st_d.on = 1'b1;
            st_d.lit = 1'b0;
            st_d.lvl = LVL_ZERO;
            st_d.pump = PCLD_PUMP_ONE;
            st_d.pump_cnt = '0;
        end
        else if (st_q.on && fall)
        begin
            if (!st_q.lit || st_q.lvl == LVL_ZERO)
                st_d.lvl = LVL_FULL;
            else
                st_d.lvl = st_q.lvl + 1'b1;
            st_d.lit = 1'b1;
        end
        if (st_q.on && !st_q.in_lvl && st_q.low_cnt == CNT_W'(OFF_CYC))
        begin
            st_d.on = 1'b0;
            st_d.lit = 1'b0;
            st_d.lvl = LVL_ZERO;
            st_d.pump = PCLD_PUMP_OFF;
        end
        // pump mode sequencing
        if (st_q.pump == PCLD_PUMP_ONE)
        begin
            if (!pump_low_i)
                st_d.pump_cnt = '0;
            else if (st_q.pump_cnt == CNT_W'(PUMP_CYC - 1))
                st_d.pump = PCLD_PUMP_HALF;
            else
                st_d.pump_cnt = st_q.pump_cnt + 1'b1;
        end
        if (undervoltage_lockout_i)
        begin
            st_d.lit = 1'b0;
            st_d.lvl = LVL_ZERO;
        end
        // shared current for both sinks from the table
        st_d.cur = st_d.lit ? pcld_current(st_d.lvl) : '0;
        st_d.hiz = !st_d.on || undervoltage_lockout_i;
    end

    // state register
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_q      <= '0;
            st_q.lvl  <= LVL_ZERO;
            st_q.hiz  <= 1'b1;
        end
        else if (clk_en_i)
            st_q <= st_d;
    end

    assign enabled_o           = st_q.on;
    assign led_sink_one_o      = st_q.cur;
    assign led_sink_two_o      = st_q.cur;
    assign led_sink_one_oe_n_o = st_q.hiz;
    assign led_sink_two_oe_n_o = st_q.hiz;
    assign pump_mode_o         = st_q.pump;
endmodule : pcld_device

// ### pcld_host.sv
// pcld_host: sends enable, dimming pulses and shutdown on the link
// assumes commands from logic on the same clock
`timescale 1ns/100ps
module pcld_host
    import pcld_pkg::*;
(
    // clock, reset, enable
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        clk_en_i,
    // user commands, taken when idle
    input  wire logic        enable_req_i,
    input  wire logic        pulse_req_i,
    input  wire logic        shutdown_req_i,
    output logic             busy_o,
    // link
    pcld_link_if.host        link
);
    typedef enum logic [2:0]
    {
        HS_OFF   = 3'b000,
        HS_SETUP = 3'b001,
        HS_IDLE  = 3'b010,
        HS_LOW   = 3'b011,
        HS_HIGH  = 3'b100,
        HS_DOWN  = 3'b101
    } pcld_hst_e;

    typedef struct packed {
        pcld_hst_e        st;
        logic [CNT_W-1:0] cnt;
        logic             line;
        logic             busy;
    } pcld_host_s;

    pcld_host_s h_q;
    pcld_host_s h_d;

    // command sequencing
    always_comb
    begin
        h_d = h_q;
        h_d.cnt = h_q.cnt + 1'b1;
        unique case (h_q.st)
            HS_OFF:
                if (enable_req_i)
                begin
                    h_d.st = HS_SETUP;
                    h_d.cnt = '0;
                end
            HS_SETUP:
                if (h_q.cnt == CNT_W'(SETUP_CYC - 1))
                    h_d.st = HS_IDLE;
            HS_IDLE:
                if (shutdown_req_i)
                begin
                    h_d.st = HS_DOWN;
                    h_d.cnt = '0;
                end
                else if (pulse_req_i)
                begin
                    h_d.st = HS_LOW;
                    h_d.cnt = '0;
                end
            HS_LOW:
                if (h_q.cnt == CNT_W'(PULSE_CYC - 1))
                begin
                    h_d.st = HS_HIGH;
                    h_d.cnt = '0;
                end
            HS_HIGH:
                if (h_q.cnt == CNT_W'(PULSE_CYC - 1))
                    h_d.st = HS_IDLE;
            HS_DOWN:
                if (h_q.cnt == CNT_W'(OFF_CYC + 8))
                    h_d.st = HS_OFF;
            default:
                h_d.st = HS_OFF;
        endcase
        h_d.line = h_d.st inside {HS_SETUP, HS_IDLE, HS_HIGH};
        h_d.busy = h_d.st != HS_IDLE && h_d.st != HS_OFF;
    end

    // state register
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            h_q <= '0;
        else if (clk_en_i)
            h_q <= h_d;
    end

    assign link.enable_dim_input = h_q.line;
    assign busy_o                = h_q.busy;
endmodule : pcld_host

// ### pcld_link_properties.sv
// pcld_link_properties: timing checks on the link and the device outputs
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/100ps
module pcld_link_properties
    import pcld_pkg::*;
(
    // clock and reset
    input wire logic             ref_clk_i,
    input wire logic             reset_i,
    // link and status inputs
    input wire logic             enable_dim_input,
    input wire logic             undervoltage_lockout_i,
    input wire logic             pump_low_i,
    // device outputs
    input wire logic             enabled_o,
    input wire logic [CUR_W-1:0] led_sink_one_o,
    input wire logic [CUR_W-1:0] led_sink_two_o,
    input wire logic             led_sink_one_oe_n_o,
    input wire logic             led_sink_two_oe_n_o,
    input wire pcld_pump_e       pump_mode_o
);
    // every check samples on the one clock
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    a_sinks_off_shut: assert property (
        !enabled_o |-> led_sink_one_oe_n_o && led_sink_two_oe_n_o)
        else $error("sink driven in shutdown");
    a_channels_match: assert property (
        led_sink_one_o == led_sink_two_o
        && led_sink_one_oe_n_o == led_sink_two_oe_n_o)
        else $error("channels differ");
    a_undervoltage_lockout_disables: assert property (
        undervoltage_lockout_i |-> ##[0:4]
        (led_sink_one_oe_n_o && led_sink_one_o == '0))
        else $error("sinks live under undervoltage");
    a_rise_enables: assert property (
        $rose(enable_dim_input) && !enabled_o && !undervoltage_lockout_i
        |-> ##[2:8] enabled_o)
        else $error("rising line did not enable");
    a_enable_zero: assert property (
        $rose(enabled_o) |-> led_sink_one_o == '0
        && pump_mode_o == PCLD_PUMP_ONE)
        else $error("enable not at zero current in 1x");
    a_fall_steps: assert property (
        $fell(enable_dim_input) && enabled_o && !undervoltage_lockout_i
        |-> ##[2:8] $changed(led_sink_one_o))
        else $error("falling edge did not step current");
    a_zero_wraps: assert property (
        $fell(enable_dim_input) && enabled_o && led_sink_one_o == '0
        && !undervoltage_lockout_i |-> ##[2:8] led_sink_one_o == 11'h5DC)
        else $error("zero level did not wrap to full");
    a_half_cause: assert property (
        $changed(pump_mode_o) && pump_mode_o == PCLD_PUMP_HALF
        |-> $past(pump_low_i))
        else $error("1.5x without low output");
endmodule : pcld_link_properties

// ### pulse_count_led_dimmer_tb.sv
// pulse_count_led_dimmer_tb: host and device joined on one link wire
// assumes a 250 MHz clock; a full 1.5 ms shutdown is longer than the run
`timescale 1ns/100ps
module pulse_count_led_dimmer_tb import pcld_pkg::*;;
    logic             ref_clk_i = 1'b0;
    logic             reset_i = 1'b1;
    logic             en_req = 1'b0;
    logic             pl_req = 1'b0;
    logic             sd_req = 1'b0;
    logic             undervoltage_lockout = 1'b0;
    logic             pump_low = 1'b0;
    logic             busy, enabled, oe_one, oe_two;
    logic [CUR_W-1:0] cur_one, cur_two, exp;
    pcld_pump_e       pump;
    int               miscompares = 0;
    int               compares = 0;
    pcld_link_if      link ();
    // the two ends and the checker
    pcld_host i_pcld_host (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .clk_en_i(1'b1), .enable_req_i(en_req), .pulse_req_i(pl_req),
        .shutdown_req_i(sd_req), .busy_o(busy), .link(link));
    pcld_device i_pcld_device (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .clk_en_i(1'b1), .link(link), .undervoltage_lockout_i(undervoltage_lockout),
        .pump_low_i(pump_low), .enabled_o(enabled),
        .led_sink_one_o(cur_one), .led_sink_two_o(cur_two),
        .led_sink_one_oe_n_o(oe_one), .led_sink_two_oe_n_o(oe_two),
        .pump_mode_o(pump));
    pcld_link_properties i_pcld_link_properties (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .enable_dim_input(link.enable_dim_input),
        .undervoltage_lockout_i(undervoltage_lockout), .pump_low_i(pump_low),
        .enabled_o(enabled), .led_sink_one_o(cur_one),
        .led_sink_two_o(cur_two), .led_sink_one_oe_n_o(oe_one),
        .led_sink_two_oe_n_o(oe_two), .pump_mode_o(pump));
    // clock, 4 ns period
    initial forever #2 ref_clk_i = ~ref_clk_i;
    task check(input logic [CUR_W-1:0] got, input logic [CUR_W-1:0] want);
        compares++;
        if (got !== want)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check
    // one host command, then wait for the host to go idle
    task host_cmd(input logic pulse);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        en_req <= !pulse;
        pl_req <= pulse;
        @(posedge ref_clk_i);
        en_req <= 1'b0;
        pl_req <= 1'b0;
        @(negedge ref_clk_i);
        while (busy !== 1'b0 && n++ < 4000)
            @(negedge ref_clk_i);
        repeat (12) @(negedge ref_clk_i);
    endtask : host_cmd
    task test_enable;
        host_cmd(1'b0);
        check({10'h000, enabled}, 11'h001);
        check(cur_one, 11'h000);
        check({9'h000, pump}, 11'h001);
        $display("test_enable done");
    endtask : test_enable
    task test_steps;
        for (int c = 1; c <= 33; c++)
        begin
            host_cmd(1'b1);
            case (c)
                1, 33:   exp = 11'h5DC;
                2:       exp = 11'h5AA;
                4:       exp = 11'h54B;
                31:      exp = 11'h032;
                default: exp = 11'h000;
            endcase
            if (c inside {1, 2, 4, 31, 32, 33})
            begin
                check(cur_one, exp);
                check(cur_two, exp);
            end
        end
        $display("test_steps done");
    endtask : test_steps
    task test_undervoltage_lockout;
        @(posedge ref_clk_i) undervoltage_lockout <= 1'b1;
        @(posedge ref_clk_i) pump_low <= 1'b1;
        repeat (50) @(negedge ref_clk_i);
        check({10'h000, oe_two}, 11'h001);
        check(cur_one, 11'h000);
        check({9'h000, pump}, 11'h001);
        @(posedge ref_clk_i) undervoltage_lockout <= 1'b0;
        pump_low <= 1'b0;
        host_cmd(1'b1);
        check(cur_one, 11'h5DC);
        $display("test_undervoltage_lockout done");
    endtask : test_undervoltage_lockout
    // long low starts: first edge steps, device stays on well inside 1.5 ms
    task test_shutdown;
        @(posedge ref_clk_i) sd_req <= 1'b1;
        @(posedge ref_clk_i) sd_req <= 1'b0;
        repeat (1000) @(negedge ref_clk_i);
        check({10'h000, enabled}, 11'h001);
        check({10'h000, busy}, 11'h001);
        check(cur_one, 11'h5AA);
        $display("test_shutdown done");
    endtask : test_shutdown
    task test_restart;
        @(posedge ref_clk_i) reset_i <= 1'b1;
        @(posedge ref_clk_i) reset_i <= 1'b0;
        @(negedge ref_clk_i);
        check({10'h000, oe_one}, 11'h001);
        test_enable();
        $display("test_restart done");
    endtask : test_restart
    task complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    // main sequence
    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        test_enable();
        test_steps();
        test_undervoltage_lockout();
        test_shutdown();
        test_restart();
        complete_run();
    end
    // watchdog, about two and a half times the expected run
    initial
    begin
        repeat (60000) @(posedge ref_clk_i);
        miscompares++;
        complete_run();
    end
endmodule : pulse_count_led_dimmer_tb
